// File: core/owc_pkg.sv
`default_nettype none
package owc_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 20000;
  localparam int BASIC_CLOCK_PERIOD_PS = 2038200;
  // A period, so rounded down; never below one cycle
  localparam int TICK_CYC_DEF = (BASIC_CLOCK_PERIOD_PS / CLK_PERIOD_PS < 1) ?
    1 : BASIC_CLOCK_PERIOD_PS / CLK_PERIOD_PS;
  // Counts below are in basic clock periods
  localparam logic [13:0] START_SHORT_MAX_DEF = 14'h1600;
  localparam logic [13:0] START_LONG_MIN_DEF = 14'h1f00;
  localparam logic [13:0] MARKER_HALF_DEF = 14'h0800;
  localparam logic [13:0] START_PULSE_WIDTH_MIN = 14'h0010;
  localparam logic [13:0] PROG_DELAY = 14'h0040;
  localparam logic [13:0] SYNC_WIDTH = 14'h0010;
  localparam logic [13:0] WIN_DELAY = 14'h0008;
  localparam logic [13:0] WIN_WIDTH = 14'h0020;
  localparam logic [13:0] EQUIVALENCE_PULSE_WIDTH = 14'h0010;
  localparam logic [13:0] EQUIVALENCE_WINDOW = 14'h0040;
  localparam logic [13:0] CNT_SAT = 14'h3fff;
  localparam logic [3:0] LAST_BIT = 4'he;
  // ==========================================================================
  // Reset values of the configuration words
  // ==========================================================================
  localparam logic [14:0] POLLING_CONFIG_WORD_DEF = 15'h0a52;
  localparam logic [14:0] LIMIT_WORD_DEF = 15'h4a4c;
  localparam int SEL_BIT = 14;
  localparam int OFF_BIT = 0;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PCFG = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_LAST = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam int CTRL_WAKE = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACK = 1;
  localparam int IRQ_OFF = 2;
  localparam int IRQ_MARKER_CLR = 3;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_SYNC, ST_GAP, ST_WIN, ST_EQW
  } owc_state_e;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
  } owc_aphase_s;
endpackage
`default_nettype wire

// File: core/owc_link.sv
// Behaviour
// RL1: After bit fifteen, open an equivalence window before ending programming.
// RL2: Drive acknowledge pulse in window only if word equals stored target word.
// RL3: Host verifies by writing the same word twice, expecting acknowledge.
// RL4: Programming is accepted in sleep state and in active receive state.
// RL5: Keep amplifier, oscillator, filter, IF amp, demodulator off while programming.
// RL6: Start pulse begins programming; bit one set returns device to polling.
// RL7: Outside reset, pulse between minimum and 5632 periods starts programming.
// RL8: In reset state, pulse under 5632 periods ignored; marker keeps toggling.
// RL9: Pulse above 7936 periods starts programming in reset or active state.
// RL10: Pulse above 7936 periods reloads default words and stops reset marker.
// RL11: Host uses long pulse after seeing marker, or with default settings.
// RL12: Host pulls line low, releases; device then becomes timing master.
// RL13: After delay, device emits 15 sync pulses, each followed by bit window.
// RL14: Host low pulse inside window programs zero; no pulse programs one.
// RL15: After reset, load defaults and output square wave marker on line.
// RL16: Host avoids start pulses between 5632 and 7936 periods.
// RL17: Start pulse measured in basic periods, restarting at each falling edge.
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`default_nettype none
module owc_link
  import owc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter logic [13:0] START_SHORT_MAX = START_SHORT_MAX_DEF,
  parameter logic [13:0] START_LONG_MIN = START_LONG_MIN_DEF,
  parameter logic [13:0] MARKER_HALF = MARKER_HALF_DEF
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  output logic [31:0] hrdata, // AHB read data
  input wire logic data_in, // Data line level
  output logic data_out, // Data line drive value
  output logic data_oe, // Data line pulled low when high
  output logic rf_enable, // Receive chain enable
  output logic polling_mode, // Device in polling state
  output logic irq // Level interrupt
);
  // ==========================================================================
  // Line sampling and basic clock
  // ==========================================================================
  logic sync1, line, line_d;
  logic [15:0] tick_cnt;
  logic tick, line_fall, line_rise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b1;
      line <= 1'b1;
      line_d <= 1'b1;
    end else begin
      sync1 <= data_in;
      line <= sync1;
      line_d <= line;
    end
  end

  assign line_fall = line_d & ~line;
  assign line_rise = ~line_d & line;
  assign tick = (tick_cnt == 16'(TICK_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 16'h0000;
    end else if (tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ==========================================================================
  // Start pulse length
  // ==========================================================================
  logic [13:0] start_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_cnt <= 14'h0000;
    end else if (line_fall) begin
      start_cnt <= 14'h0000; // RL17
    end else if (!line && tick && start_cnt != CNT_SAT) begin
      start_cnt <= start_cnt + 14'h0001; // RL17
    end
  end

  // ==========================================================================
  // Programming sequencer
  // ==========================================================================
  owc_state_e state;
  logic [13:0] tcnt;
  logic [3:0] bit_idx;
  logic [14:0] word;
  logic win_low, eq_match, reset_mode;
  logic start_eval, go_long, go_short, phase_end, eqw_end, win_end;
  assign start_eval = (state == ST_IDLE) && line_rise && !data_oe;
  assign go_long = start_eval && (start_cnt > START_LONG_MIN); // RL9
  assign go_short = start_eval && !reset_mode && // RL7
    (start_cnt > START_PULSE_WIDTH_MIN) && (start_cnt < START_SHORT_MAX);
  function automatic logic [13:0] phase_len(input owc_state_e s);
    case (s)
      ST_DELAY: phase_len = PROG_DELAY;
      ST_SYNC: phase_len = SYNC_WIDTH;
      ST_GAP: phase_len = WIN_DELAY;
      ST_WIN: phase_len = WIN_WIDTH;
      ST_EQW: phase_len = EQUIVALENCE_WINDOW;
      default: phase_len = 14'h0001;
    endcase
  endfunction

  assign phase_end = tick && (tcnt == phase_len(state) - 14'h0001);
  assign win_end = (state == ST_WIN) && phase_end;
  assign eqw_end = (state == ST_EQW) && phase_end;
  logic [14:0] pcfg_word, limit_word, target_word;
  // Selected by the bit being captured now, not the stale word[14]
  assign target_word = (win_low | ~line) ? pcfg_word : limit_word; // RL2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      tcnt <= 14'h0000;
      bit_idx <= 4'h0;
      word <= 15'h0000;
      win_low <= 1'b0;
      eq_match <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          tcnt <= 14'h0000;
          bit_idx <= 4'h0;
          if (go_long || go_short) begin
            state <= ST_DELAY; // RL4 RL12
          end
        end
        ST_DELAY, ST_SYNC, ST_GAP: begin
          if (phase_end) begin
            tcnt <= 14'h0000;
            win_low <= 1'b0;
            state <= (state == ST_DELAY) ? ST_SYNC : // RL13
              (state == ST_SYNC) ? ST_GAP : ST_WIN;
          end else if (tick) begin
            tcnt <= tcnt + 14'h0001;
          end
        end
        ST_WIN: begin
          if (!line) begin
            win_low <= 1'b1;
          end
          if (phase_end) begin
            tcnt <= 14'h0000;
            word[bit_idx] <= ~(win_low | ~line); // RL14
            if (bit_idx == LAST_BIT) begin
              eq_match <= ({~(win_low | ~line), word[13:0]} ==
                target_word); // RL2
              state <= ST_EQW; // RL1
            end else begin
              bit_idx <= bit_idx + 4'h1;
              state <= ST_SYNC; // RL13
            end
          end else if (tick) begin
            tcnt <= tcnt + 14'h0001;
          end
        end
        ST_EQW: begin
          if (phase_end) begin
            state <= ST_IDLE;
          end else if (tick) begin
            tcnt <= tcnt + 14'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Configuration words, reset marker, receive state
  // ==========================================================================
  logic [13:0] marker_cnt;
  logic marker_low, active;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcfg_word <= POLLING_CONFIG_WORD_DEF; // RL15
      limit_word <= LIMIT_WORD_DEF;
    end else if (go_long) begin
      pcfg_word <= POLLING_CONFIG_WORD_DEF; // RL10
      limit_word <= LIMIT_WORD_DEF;
    end else if (eqw_end) begin
      if (word[SEL_BIT]) begin
        limit_word <= word;
      end else begin
        pcfg_word <= word;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_mode <= 1'b1;
      marker_cnt <= 14'h0000;
      marker_low <= 1'b0;
    end else begin
      if (go_long) begin
        reset_mode <= 1'b0; // RL10
      end
      if (tick) begin
        if (marker_cnt == MARKER_HALF - 14'h0001) begin
          marker_cnt <= 14'h0000;
          marker_low <= ~marker_low; // RL15 RL8
        end else begin
          marker_cnt <= marker_cnt + 14'h0001;
        end
      end
    end
  end
  logic bus_wake, bus_sleep;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active <= 1'b0;
    end else if (eqw_end && word[OFF_BIT]) begin
      active <= 1'b0; // RL6
    end else if (bus_sleep) begin
      active <= 1'b0;
    end else if (bus_wake) begin
      active <= 1'b1;
    end
  end

  assign data_out = 1'b0;
  assign data_oe = (state == ST_SYNC) || // RL13
    ((state == ST_EQW) && eq_match &&
      (tcnt < EQUIVALENCE_PULSE_WIDTH)) || // RL2
    ((state == ST_IDLE) && reset_mode && marker_low); // RL15
  assign rf_enable = active && (state == ST_IDLE); // RL5
  assign polling_mode = !active;
  // ==========================================================================
  // AHB-Lite slave and interrupts
  // ==========================================================================
  owc_aphase_s aph;
  logic [3:0] irq_stat, irq_mask, irq_ev;
  logic wr_en;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = aph.valid && aph.wr;
  assign bus_wake = wr_en && aph.addr == OFS_CTRL && hwdata[CTRL_WAKE];
  assign bus_sleep = wr_en && aph.addr == OFS_CTRL && hwdata[CTRL_SLEEP];
  assign irq_ev = {go_long && reset_mode, eqw_end && word[OFF_BIT],
    eqw_end && eq_match, eqw_end};
  assign irq = |(irq_stat & irq_mask);
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      OFS_CTRL: reg_read = {31'h00000000, active};
      OFS_STATUS: reg_read = {24'h000000, bit_idx, eq_match,
        state != ST_IDLE, reset_mode, active};
      OFS_PCFG: reg_read = {17'h00000, pcfg_word};
      OFS_LIMIT: reg_read = {17'h00000, limit_word};
      OFS_LAST: reg_read = {17'h00000, word};
      OFS_IRQ_STAT: reg_read = {28'h0000000, irq_stat};
      OFS_IRQ_MASK: reg_read = {28'h0000000, irq_mask};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      aph.valid <= hsel && htrans[1];
      aph.wr <= hwrite;
      aph.addr <= {haddr[7:2], 2'b00};
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= reg_read({haddr[7:2], 2'b00});
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
    end else begin
      if (wr_en && aph.addr == OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~hwdata[3:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      if (wr_en && aph.addr == OFS_IRQ_MASK) begin
        irq_mask <= hwdata[3:0];
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_eqw_after_last;
    win_end && bit_idx == LAST_BIT |=> state == ST_EQW;
  endproperty
  a_eqw_after_last: assert property (p_eqw_after_last) // RL1
    else $error("equivalence window did not follow last bit");
  property p_ack_needs_match;
    state == ST_EQW && !eq_match |-> !data_oe;
  endproperty
  a_ack_needs_match: assert property (p_ack_needs_match) // RL2
    else $error("acknowledge driven without match");
  property p_start_asleep;
    go_long && !active |=> state == ST_DELAY;
  endproperty
  a_start_asleep: assert property (p_start_asleep) // RL4
    else $error("programming not started from sleep");
  property p_rf_off;
    state != ST_IDLE |-> !rf_enable;
  endproperty
  a_rf_off: assert property (p_rf_off) // RL5
    else $error("receive chain enabled while programming");
  property p_off_cmd;
    eqw_end && word[OFF_BIT] |=> polling_mode && state == ST_IDLE;
  endproperty
  a_off_cmd: assert property (p_off_cmd) // RL6
    else $error("off command did not return to polling");
  property p_short_start;
    start_eval && !reset_mode && start_cnt > START_PULSE_WIDTH_MIN &&
      start_cnt < START_SHORT_MAX |=> state == ST_DELAY;
  endproperty
  a_short_start: assert property (p_short_start) // RL7
    else $error("short start pulse not accepted");
  property p_short_ignored;
    start_eval && reset_mode && start_cnt <= START_LONG_MIN
      |=> state == ST_IDLE && reset_mode;
  endproperty
  a_short_ignored: assert property (p_short_ignored) // RL8
    else $error("short pulse accepted in reset state");
  property p_long_start;
    go_long |=> state == ST_DELAY && !reset_mode &&
      pcfg_word == POLLING_CONFIG_WORD_DEF && limit_word == LIMIT_WORD_DEF;
  endproperty
  a_long_start: assert property (p_long_start) // RL9 RL10
    else $error("long start pulse handled wrongly");
  property p_sync_drive;
    state == ST_SYNC |-> data_oe;
  endproperty
  a_sync_drive: assert property (p_sync_drive) // RL13
    else $error("sync pulse not driven");
  property p_bit_value;
    win_end |=> word[$past(bit_idx)] == !($past(win_low) || !$past(line));
  endproperty
  a_bit_value: assert property (p_bit_value) // RL14
    else $error("captured bit wrong");
  property p_marker;
    state == ST_IDLE && reset_mode && marker_low |-> data_oe;
  endproperty
  a_marker: assert property (p_marker) // RL15
    else $error("reset marker not driven");
  property p_cnt_restart;
    line_fall |=> start_cnt == 14'h0000;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) // RL17
    else $error("start counter not restarted");

  c_long: cover property (go_long);
  c_ack: cover property (eqw_end && eq_match);
  c_off: cover property (eqw_end && word[OFF_BIT]);
endmodule
`default_nettype wire

// File: verif/owc_host.sv
`default_nettype none
module owc_host #(
  parameter int TICK = 2
) (
  input wire logic hclk, // System clock
  input wire logic line, // Resolved data line level
  output logic host_oe, // High pulls the line low
  output logic in_xfer // High while the device clocks bits
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Line drive
  // ==========================================================================
  initial begin
    host_oe = 1'b0;
    in_xfer = 1'b0;
  end

  // Start pulse, then release so the device can take the line
  task automatic hold_low(input int ticks);
    @(posedge hclk);
    host_oe <= 1'b1;
    repeat (ticks * TICK) @(posedge hclk);
    host_oe <= 1'b0;
  endtask

  // Whole transfer; ack tells of a low seen in the equivalence window
  task automatic xfer(input int ticks, input logic [14:0] word,
                      output logic ack);
    ack = 1'b0;
    hold_low(ticks);
    for (int b = 0; b < 15; b++) begin
      @(negedge line);
      in_xfer <= 1'b1;
      @(posedge line);
      repeat (16 * TICK) @(posedge hclk);
      if (!word[b])
        hold_low(8);
      else
        repeat (8 * TICK + 1) @(posedge hclk);
    end
    repeat (16 * TICK) @(posedge hclk);
    for (int n = 0; n < 60 * TICK; n++) begin
      @(posedge hclk);
      if (!line)
        ack = 1'b1;
    end
    in_xfer <= 1'b0;
    repeat (10 * TICK) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// File: verif/owc_link_tb.sv
`default_nettype none
module owc_link_tb
  import owc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Setup
  // ==========================================================================
  localparam int TICK = 2;
  localparam logic [13:0] MARKER_H = 14'd20;
  // Start lengths stay outside the band between the limits
  localparam int SHORT_T = 30;
  localparam int LONG_T = 70;
  localparam logic [14:0] W_A = 15'h1234;
  localparam logic [14:0] W_B = 15'h4a4d;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, data_out, data_oe, rf_enable, polling_mode, irq;
  logic [31:0] hrdata;
  logic host_oe, in_xfer;
  wire hready;
  wire line;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  assign hready = hreadyout;
  // Pulled-up open-drain line
  assign line = !(host_oe || (data_oe && !data_out));

  always #10 hclk = ~hclk;

  owc_link #(
    .TICK_CYC(TICK),
    .START_SHORT_MAX(14'd40),
    .START_LONG_MIN(14'd60),
    .MARKER_HALF(MARKER_H)
  ) i_owc_link (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .data_in(line),
    .data_out(data_out),
    .data_oe(data_oe),
    .rf_enable(rf_enable),
    .polling_mode(polling_mode),
    .irq(irq)
  );

  owc_host #(
    .TICK(TICK)
  ) i_owc_host (
    .hclk(hclk),
    .line(line),
    .host_oe(host_oe),
    .in_xfer(in_xfer)
  );
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(name, v & m, exp);
  endtask

  // Marker level must flip after exactly one half period
  task automatic marker_chk();
    logic a;
    @(posedge hclk);
    #1;
    a = data_oe;
    repeat (int'(MARKER_H) * TICK) @(posedge hclk);
    #1;
    check("marker", 32'(data_oe), 32'(!a));
  endtask

  // Looked at mid-cycle, away from the edge that launches the outputs
  always @(negedge hclk) begin
    cycles++;
    check("hresp", 32'(hresp), 32'h0);
    check("data_out", 32'(data_out), 32'h0);
    if (in_xfer)
      check("rf_enable", 32'(rf_enable), 32'h0);
    if (cycles == 30000) begin
      err_count++;
      conclude();
    end
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic ack;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("status", OFS_STATUS, 32'h7, 32'h2);
    rd_chk("pcfg", OFS_PCFG, 32'h7fff, 32'(POLLING_CONFIG_WORD_DEF));
    rd_chk("limit", OFS_LIMIT, 32'h7fff, 32'(LIMIT_WORD_DEF));
    rd_chk("unmapped", 8'h40, 32'hffffffff, 32'h0);
    marker_chk();
    // Short start while the marker runs
    i_owc_host.hold_low(SHORT_T);
    repeat (10) @(posedge hclk);
    rd_chk("status", OFS_STATUS, 32'h7, 32'h2);
    marker_chk();
    // Long start leaves reset state
    wr(OFS_IRQ_MASK, 32'h1);
    i_owc_host.xfer(LONG_T, W_A, ack);
    check("ack", 32'(ack), 32'h0);
    rd_chk("status", OFS_STATUS, 32'h7, 32'h0);
    rd_chk("pcfg", OFS_PCFG, 32'h7fff, 32'(W_A));
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'hf, 32'h9);
    #1;
    check("irq", 32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'hf);
    #1;
    check("irq", 32'(irq), 32'h0);
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'hf, 32'h0);
    // Same word again while active
    wr(OFS_CTRL, 32'h1);
    #1;
    check("polling_mode", 32'(polling_mode), 32'h0);
    i_owc_host.xfer(SHORT_T, W_A, ack);
    check("ack", 32'(ack), 32'h1);
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'hf, 32'h3);
    rd_chk("status", OFS_STATUS, 32'h7, 32'h1);
    // Sleep wins over wake in one write, then wake again
    wr(OFS_CTRL, 32'h3);
    rd_chk("ctrl", OFS_CTRL, 32'h1, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rd_chk("ctrl", OFS_CTRL, 32'h1, 32'h1);
    #1;
    check("rf_enable", 32'(rf_enable), 32'h1);
    // OFF command into the limit word
    i_owc_host.xfer(SHORT_T, W_B, ack);
    check("ack", 32'(ack), 32'h0);
    rd_chk("limit", OFS_LIMIT, 32'h7fff, 32'(W_B));
    rd_chk("last", OFS_LAST, 32'hffffffff, 32'(W_B));
    rd_chk("irq_mask", OFS_IRQ_MASK, 32'hffffffff, 32'h1);
    rd_chk("status", OFS_STATUS, 32'h7, 32'h0);
    #1;
    check("polling_mode", 32'(polling_mode), 32'h1);
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'hf, 32'h7);
    // Pulse below the minimum is ignored
    i_owc_host.hold_low(8);
    repeat (10) @(posedge hclk);
    rd_chk("status", OFS_STATUS, 32'h7, 32'h0);
    // Long start outside reset reloads defaults
    i_owc_host.xfer(LONG_T, POLLING_CONFIG_WORD_DEF, ack);
    check("ack", 32'(ack), 32'h1);
    rd_chk("limit", OFS_LIMIT, 32'h7fff, 32'(LIMIT_WORD_DEF));
    conclude();
  end
endmodule
`default_nettype wire
